// ---- src/qao_register_bank.sv ----
// Summary of operation
// - four signed 16-bit setpoints at register numbers 2, 4, 6, 8, cyclic.
// - in-range setpoint drives that channel's converter to the value.
// - zero setpoint turns channel indicator off, non-zero turns it on.
// - channel-type word at register 0, non-cyclic write only.
// - bits 8..11 pick current per channel; other bits reserved zero.
// - bus-controller layout puts setpoints at object bytes 0,2,4,6.
// - on CAN I/O the module occupies exactly one analog slot.
// - every bus cycle of 200 us or more gets an output update.
// - four output channels, 16-bit resolution including sign.
`timescale 1ns/1ps
`default_nettype none
`include "qao_defines.svh"
module qao_register_bank
  import qao_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  input wire logic WR_VALID,
  input wire logic WR_CYCLIC,
  input wire logic WR_LAYOUT_BC,
  input wire logic [7:0] WR_ADDR,
  input wire logic [15:0] WR_DATA,
  input wire logic CYCLE_START,
  output logic DAC_LOAD,
  output logic [1:0] DAC_CHAN,
  output logic DAC_CURRENT,
  output logic [15:0] DAC_CODE,
  output logic [3:0] CHAN_LED,
  output logic [15:0] CHANNEL_TYPE,
  output logic [3:0] SLOT_COUNT
);
  qao_wr_type wr;
  qao_dac_type dac;
  qao_state_type state;
  logic [15:0] type_word;
  logic [1:0] wr_chan;
  logic wr_is_sp;
  logic range_ok;
  logic sp_we;
  logic [1:0] scan;
  logic [15:0] mem_rdata;
  logic [1:0] mem_chan;
  logic mem_load;

  assign wr = '{valid: WR_VALID, cyclic: WR_CYCLIC, layout_bc: WR_LAYOUT_BC,
                addr: WR_ADDR, data: WR_DATA};

  // map a write address to a setpoint channel in either layout
  function automatic logic [2:0] sp_decode(input logic bc,
                                           input logic [7:0] a);
    logic [2:0] r;
    r = 3'b000;
    if (bc) begin
      unique case (a)
        `QAO_OBJ_SP1: r = 3'b100;
        `QAO_OBJ_SP2: r = 3'b101;
        `QAO_OBJ_SP3: r = 3'b110;
        `QAO_OBJ_SP4: r = 3'b111;
        default: r = 3'b000;
      endcase
    end else begin
      unique case (a)
        `QAO_REG_SP1: r = 3'b100;
        `QAO_REG_SP2: r = 3'b101;
        `QAO_REG_SP3: r = 3'b110;
        `QAO_REG_SP4: r = 3'b111;
        default: r = 3'b000;
      endcase
    end
    return r;
  endfunction : sp_decode

  // setpoints are cyclic writes only
  always_comb begin
    logic [2:0] d;
    d = sp_decode(wr.layout_bc, wr.addr);
    wr_is_sp = wr.valid && wr.cyclic && d[2];
    wr_chan = d[1:0];
  end

  qao_range_check u_range (
    .value(wr.data),
    .current(type_word[`QAO_TYPE_LSB + wr_chan]),
    .ok(range_ok)
  );

  assign sp_we = wr_is_sp && range_ok;

  // scan pointer rotates through channels loading converters
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      scan <= 2'b00;
      state <= QAO_IDLE;
    end else if (CE) begin
      unique case (state)
        QAO_IDLE: begin
          if (CYCLE_START) begin
            state <= QAO_LOAD;
            scan <= 2'b00;
          end
        end
        QAO_LOAD: begin
          scan <= scan + 2'b01;
          if (scan == 2'(CHANNELS - 1))
            state <= QAO_IDLE;
        end
        default: state <= QAO_IDLE;
      endcase
    end
  end

  qao_setpoint_mem #(.WIDTH(16), .DEPTH(CHANNELS)) u_mem (
    .clk(CLOCK),
    .rst(RST),
    .ce(CE),
    .we(sp_we),
    .waddr(wr_chan),
    .wdata(wr.data),
    .raddr(scan),
    .rdata(mem_rdata)
  );

  // channel-type word, non-cyclic writes to register 0 only
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST)
      type_word <= `QAO_TYPE_RESET;
    else if (CE && wr.valid && !wr.cyclic && !wr.layout_bc &&
             wr.addr == `QAO_REG_TYPE)
      type_word <= wr.data & `QAO_TYPE_MASK;
  end

  // converter load pipeline follows the registered memory read
  // the strobe takes two stages so it meets its own channel and code
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      DAC_LOAD <= 1'b0;
      mem_load <= 1'b0;
      mem_chan <= 2'b00;
    end else if (CE) begin
      mem_load <= (state == QAO_LOAD);
      DAC_LOAD <= mem_load;
      mem_chan <= scan;
    end
  end

  assign dac = '{chan: mem_chan,
                 current: type_word[`QAO_TYPE_LSB + mem_chan],
                 code: mem_rdata};

  // converter data, 16-bit signed per channel
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      DAC_CHAN <= 2'b00;
      DAC_CURRENT <= 1'b0;
      DAC_CODE <= 16'h0000;
    end else if (CE) begin
      DAC_CHAN <= dac.chan;
      DAC_CURRENT <= dac.current;
      DAC_CODE <= dac.code;
    end
  end

  // indicators track applied setpoints as they are accepted
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST)
      CHAN_LED <= 4'h0;
    else if (CE && sp_we)
      CHAN_LED[wr_chan] <= (wr.data != 16'h0000);
  end

  // type word and slot count copied out to the module's output ports
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CHANNEL_TYPE <= `QAO_TYPE_RESET;
      SLOT_COUNT <= 4'h0;
    end else if (CE) begin
      CHANNEL_TYPE <= type_word;
      SLOT_COUNT <= `QAO_SLOTS;
    end
  end

  // assertions
  property led_tracks_p;
    @(posedge CLOCK) disable iff (RST)
      (CE && sp_we) |=> (CHAN_LED[$past(wr_chan)] == ($past(wr.data) != 0));
  endproperty
  led_zero_a: assert property (led_tracks_p)
    else $error("indicator does not track setpoint");

  // a voltage code of 0x8000 lies one step below the permitted range
  bad_reject_a: assert property (@(posedge CLOCK)
    disable iff (RST) (wr_is_sp && wr.data == 16'h8000) |-> !sp_we)
    else $error("out of range value accepted");

  // current channels take no negative codes
  cur_reject_a: assert property (@(posedge CLOCK)
    disable iff (RST) (wr_is_sp && type_word[`QAO_TYPE_LSB + wr_chan] &&
      wr.data[15]) |-> !sp_we)
    else $error("negative current accepted");

  // every in-range code of either type is taken
  volt_accept_a: assert property (@(posedge CLOCK)
    disable iff (RST) (wr_is_sp && !type_word[`QAO_TYPE_LSB + wr_chan] &&
      wr.data != 16'h8000) |-> sp_we)
    else $error("valid voltage setpoint refused");

  cur_accept_a: assert property (@(posedge CLOCK)
    disable iff (RST) (wr_is_sp && type_word[`QAO_TYPE_LSB + wr_chan] &&
      !wr.data[15]) |-> sp_we)
    else $error("valid current setpoint refused");

  // reserved bits of the type word never hold a one
  type_resv_a: assert property (@(posedge CLOCK)
    disable iff (RST) (type_word & ~`QAO_TYPE_MASK) == 16'h0000)
    else $error("reserved type bits set");

  // a non-cyclic write to register 0 loads the channel bits
  type_write_a: assert property (@(posedge CLOCK)
    disable iff (RST) (CE && wr.valid && !wr.cyclic && !wr.layout_bc &&
      wr.addr == `QAO_REG_TYPE) |=>
      type_word == ($past(wr.data) & `QAO_TYPE_MASK))
    else $error("type word write not taken");

  cyc_type_a: assert property (@(posedge CLOCK)
    disable iff (RST) (CE && wr.valid && wr.cyclic) |=> $stable(type_word))
    else $error("cyclic write changed type word");

  // the type word copy follows one enabled cycle later
  type_show_a: assert property (@(posedge CLOCK)
    disable iff (RST) CE |=> CHANNEL_TYPE == $past(type_word))
    else $error("type word copy lags");

  // setpoints need a cyclic write at a mapped, even address
  noncyc_sp_a: assert property (@(posedge CLOCK)
    disable iff (RST) (wr.valid && !wr.cyclic) |-> !sp_we)
    else $error("non-cyclic setpoint write taken");

  odd_addr_a: assert property (@(posedge CLOCK)
    disable iff (RST) (wr.valid && wr.addr[0]) |-> !wr_is_sp)
    else $error("odd address mapped to a setpoint");

  sp_accept_a: assert property (@(posedge CLOCK)
    disable iff (RST) (CE && wr.valid && wr.cyclic && !wr.layout_bc &&
      wr.addr == `QAO_REG_SP1 && !wr.data[15]) |->
      sp_we && wr_chan == 2'b00)
    else $error("channel 1 setpoint not taken");

  sp_last_a: assert property (@(posedge CLOCK)
    disable iff (RST) (wr.valid && wr.cyclic && !wr.layout_bc &&
      wr.addr == `QAO_REG_SP4) |-> wr_is_sp && wr_chan == 2'b11)
    else $error("register 8 not channel 4");

  bc_map_a: assert property (@(posedge CLOCK)
    disable iff (RST) (wr.valid && wr.cyclic && wr.layout_bc &&
      wr.addr == `QAO_OBJ_SP4) |-> wr_is_sp && wr_chan == 2'b11)
    else $error("object offset 6 not channel 4");

  // indicators change only on an accepted setpoint
  led_hold_a: assert property (@(posedge CLOCK)
    disable iff (RST) (CE && !sp_we) |=> $stable(CHAN_LED))
    else $error("indicator changed without setpoint");

  // a scan takes one enabled cycle per channel and then stops
  scan_end_a: assert property (@(posedge CLOCK)
    disable iff (RST) (CE && state == QAO_LOAD &&
      scan == 2'(CHANNELS - 1)) |=> state == QAO_IDLE)
    else $error("scan ran past last channel");

  // an accepted start gives four loads, channels in order, from c3
  sequence start_s;
    CE && CYCLE_START && state == QAO_IDLE;
  endsequence
  sequence four_loads_s;
    (DAC_LOAD && DAC_CHAN == 2'b00) ##1 (DAC_LOAD && DAC_CHAN == 2'b01) ##1
      (DAC_LOAD && DAC_CHAN == 2'b10) ##1 (DAC_LOAD && DAC_CHAN == 2'b11);
  endsequence
  update_cycle_a: assert property (@(posedge CLOCK)
    disable iff (RST || !CE) start_s |-> ##3 four_loads_s)
    else $error("update cycle not started");

  load_count_a: assert property (@(posedge CLOCK)
    disable iff (RST) (start_s ##1 CE[*5]) |-> ##[0:1]
      (DAC_LOAD && DAC_CHAN == 2'b11))
    else $error("four channels not loaded");

  load_stop_a: assert property (@(posedge CLOCK)
    disable iff (RST) (CE && DAC_LOAD && DAC_CHAN == 2'b11) |=> !DAC_LOAD)
    else $error("extra converter load");

  // nothing moves while the clock enable is low
  freeze_fsm_a: assert property (@(posedge CLOCK)
    disable iff (RST) !CE |=> $stable(state) && $stable(scan))
    else $error("scan moved while disabled");

  freeze_out_a: assert property (@(posedge CLOCK)
    disable iff (RST) !CE |=> $stable(DAC_LOAD) && $stable(DAC_CODE) &&
      $stable(CHAN_LED))
    else $error("outputs moved while disabled");

  // one logical slot is reported once running
  slot_one_a: assert property (@(posedge CLOCK)
    disable iff (RST) CE |=> SLOT_COUNT == `QAO_SLOTS)
    else $error("slot count wrong");
endmodule : qao_register_bank
`default_nettype wire

// ---- include/qao_defines.svh ----
`ifndef QAO_DEFINES_SVH
`define QAO_DEFINES_SVH
// register numbers, standard layout
`define QAO_REG_TYPE 8'h00
`define QAO_REG_SP1 8'h02
`define QAO_REG_SP2 8'h04
`define QAO_REG_SP3 8'h06
`define QAO_REG_SP4 8'h08
// byte offsets within the bus-controller object
`define QAO_OBJ_SP1 8'h00
`define QAO_OBJ_SP2 8'h02
`define QAO_OBJ_SP3 8'h04
`define QAO_OBJ_SP4 8'h06
// channel-type field
`define QAO_TYPE_LSB 8
`define QAO_TYPE_MASK 16'h0f00
`define QAO_TYPE_RESET 16'h0000
// setpoint limits
`define QAO_SP_MAX 16'sh7fff
`define QAO_SP_MIN_V -16'sh7fff
`define QAO_SP_MIN_I 16'sh0000
// logical slots occupied
`define QAO_SLOTS 4'h1
// least bus cycle and converter update timing
`define QAO_CYCLE_MIN_US 200
`define QAO_CLK_MHZ 250
`define QAO_CYCLE_MIN_CLK (`QAO_CYCLE_MIN_US * `QAO_CLK_MHZ)
`endif

// ---- include/qao_pkg.sv ----
package qao_pkg;
  // one register access from the controller
  typedef struct packed {
    logic valid;
    logic cyclic;
    logic layout_bc;
    logic [7:0] addr;
    logic [15:0] data;
  } qao_wr_type;
  // one converter load
  typedef struct packed {
    logic [1:0] chan;
    logic current;
    logic [15:0] code;
  } qao_dac_type;
  typedef enum logic [1:0] {
    QAO_IDLE = 2'b00,
    QAO_LOAD = 2'b01
  } qao_state_type;
endpackage : qao_pkg

// ---- src/qao_range_check.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "qao_defines.svh"
module qao_range_check
  import qao_pkg::*;
(
  input wire logic [15:0] value,
  input wire logic current,
  output logic ok
);
  // permitted range depends on channel type
  always_comb begin
    if (current)
      ok = ($signed(value) >= `QAO_SP_MIN_I);
    else
      ok = ($signed(value) >= `QAO_SP_MIN_V);
  end
endmodule : qao_range_check
`default_nettype wire

// ---- src/qao_setpoint_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module qao_setpoint_mem
  import qao_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  // applied setpoints, cleared to zero output at reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
    end else if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end
  // registered read port
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      rdata <= '0;
    else if (ce)
      rdata <= mem[raddr];
  end
endmodule : qao_setpoint_mem
`default_nettype wire

// ---- sim/qao_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module qao_ctrl_model
  import qao_pkg::*;
(
  input wire logic clk,
  output logic wr_valid,
  output logic wr_cyclic,
  output logic wr_layout_bc,
  output logic [7:0] wr_addr,
  output logic [15:0] wr_data,
  output logic cycle_start
);
  // bus idle at time zero
  initial begin
    wr_valid = 1'b0;
    wr_cyclic = 1'b0;
    wr_layout_bc = 1'b0;
    wr_addr = 8'h00;
    wr_data = 16'h0000;
    cycle_start = 1'b0;
  end
  // one write, held for exactly one taking edge
  task automatic wr(input logic c, input logic b, input logic [7:0] a,
                    input logic [15:0] d);
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_cyclic <= c;
    wr_layout_bc <= b;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_valid <= 1'b0;
    wr_addr <= ~a; // released lines carry no stale value
    wr_data <= ~d;
  endtask : wr
  // start pulse, then the rest of a shortened bus cycle
  task automatic bus_cycle();
    @(posedge clk);
    cycle_start <= 1'b1;
    @(posedge clk);
    cycle_start <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : bus_cycle
endmodule : qao_ctrl_model
`default_nettype wire

// ---- sim/quad_analog_output_register_bank_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "qao_defines.svh"
module quad_analog_output_register_bank_tb
  import qao_pkg::*;
;
  typedef struct packed {
    logic c;
    logic b;
    logic [7:0] a;
    logic [15:0] d;
    logic [1:0] ch;
    logic [15:0] code;
  } qao_row_type;
  localparam qao_row_type ROWS [8] = '{
    '{1'b1, 1'b0, `QAO_REG_SP1, 16'h0005, 2'h0, 16'h0005},
    '{1'b1, 1'b0, `QAO_REG_SP2, 16'h7fff, 2'h1, 16'h7fff},
    '{1'b1, 1'b0, `QAO_REG_SP3, 16'h8001, 2'h2, 16'h8001},
    '{1'b1, 1'b1, `QAO_OBJ_SP4, 16'h0042, 2'h3, 16'h0042},
    '{1'b1, 1'b1, `QAO_OBJ_SP1, 16'h1234, 2'h0, 16'h1234},
    '{1'b1, 1'b0, `QAO_REG_SP4, 16'h0000, 2'h3, 16'h0000},
    '{1'b1, 1'b0, `QAO_REG_SP1, 16'h8000, 2'h0, 16'h1234},
    '{1'b0, 1'b0, `QAO_REG_SP2, 16'h0001, 2'h1, 16'h7fff}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic v, cyc, bc, cs, ld, cur;
  logic [7:0] addr;
  logic [15:0] data, code, ctype;
  logic [1:0] chan;
  logic [3:0] led, slots;
  logic [15:0] got_code [4];
  logic got_cur [4];
  int loads = 0;
  int fail_count = 0;
  int num_checks = 0;
  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end
  qao_ctrl_model ctl (.clk(clk), .wr_valid(v), .wr_cyclic(cyc),
    .wr_layout_bc(bc), .wr_addr(addr), .wr_data(data), .cycle_start(cs));
  qao_register_bank dut (.CLOCK(clk), .RST(rst), .CE(ce), .WR_VALID(v),
    .WR_CYCLIC(cyc), .WR_LAYOUT_BC(bc), .WR_ADDR(addr), .WR_DATA(data),
    .CYCLE_START(cs), .DAC_LOAD(ld), .DAC_CHAN(chan), .DAC_CURRENT(cur),
    .DAC_CODE(code), .CHAN_LED(led), .CHANNEL_TYPE(ctype),
    .SLOT_COUNT(slots));
  // converter loads captured per channel
  always @(posedge clk) begin
    if (ld === 1'b1) begin
      got_code[chan] = code;
      got_cur[chan] = cur;
      loads++;
    end
  end
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one bus cycle with its four loads counted
  task automatic scan();
    loads = 0;
    ctl.bus_cycle();
    chk("loads", 16'h0004, 16'(loads));
  endtask : scan
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  // watchdog against a hung run
  initial begin
    #20us;
    fail_count++;
    $display("ERROR watchdog expected done seen hang");
    summarize();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("slots", 16'h0001, {12'h0, slots});
    chk("type", `QAO_TYPE_RESET, ctype);
    foreach (ROWS[i]) begin
      ctl.wr(ROWS[i].c, ROWS[i].b, ROWS[i].a, ROWS[i].d);
      scan();
      chk("code", ROWS[i].code, got_code[ROWS[i].ch]);
      chk("led", {15'h0, ROWS[i].code != 0}, {15'h0, led[ROWS[i].ch]});
      chk("cur", 16'h0, {15'h0, got_cur[ROWS[i].ch]});
    end
    $display("test table done");
    ctl.wr(1'b0, 1'b0, `QAO_REG_TYPE, 16'hffff);
    ctl.wr(1'b1, 1'b0, `QAO_REG_TYPE, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    chk("type", `QAO_TYPE_MASK, ctype);
    ctl.wr(1'b1, 1'b0, `QAO_REG_SP2, 16'hffff);
    ctl.wr(1'b1, 1'b0, `QAO_REG_SP3, 16'h0100);
    scan();
    chk("refused", 16'h7fff, got_code[1]);
    chk("applied", 16'h0100, got_code[2]);
    chk("cur", 16'h1, {15'h0, got_cur[2]});
    $display("test current done");
    ce <= 1'b0;
    ctl.wr(1'b1, 1'b0, `QAO_REG_SP1, 16'h0011);
    ce <= 1'b1;
    scan();
    chk("frozen", 16'h1234, got_code[0]);
    $display("test freeze done");
    rst <= 1'b1;
    @(posedge clk);
    #1;
    chk("rst type", 16'h0, ctype);
    chk("rst led", 16'h0, {12'h0, led});
    @(posedge clk);
    rst <= 1'b0;
    scan();
    chk("rst code", 16'h0000, got_code[1]);
    chk("rst cur", 16'h0, {15'h0, got_cur[2]});
    $display("test reset done");
    summarize();
  end
endmodule : quad_analog_output_register_bank_tb
`default_nettype wire
